// ---- logic/mfd_decoder.sv ----
// Purpose: Manchester edge-interval decoder and frame parser with output FIFO
// Assumes: rf_data is asynchronous; bits are sent MSB first
// Notes: decoded data words leave through a 16-entry FIFO
`timescale 1ns/1ps

// ------------------------------------------------------------------
// output FIFO
// ------------------------------------------------------------------
module mfd_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  // pointers wrap naturally, so depth must be a power of two
  assign in_ready = (count != CW'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

  // registered output stage keeps the drain side glitch free
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule : mfd_fifo

// ------------------------------------------------------------------
// decoder
// ------------------------------------------------------------------
module mfd_decoder #(
  parameter int BIT_CYCLES = mfd_pkg::BIT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // receiver line
  input wire logic rf_data,
  // decoded frames
  output logic [mfd_pkg::DATA_BITS-1:0] frame_data,
  output logic frame_valid,
  input wire logic frame_ready,
  // status
  output logic sync_locked,
  output logic decode_error,
  output logic frame_drop
);
  import mfd_pkg::*;

  localparam logic [TS_W-1:0] WIN_1_LO = TS_W'(BIT_CYCLES * Q_1_LO / 4);
  localparam logic [TS_W-1:0] WIN_15_LO = TS_W'(BIT_CYCLES * Q_15_LO / 4);
  localparam logic [TS_W-1:0] WIN_2_LO = TS_W'(BIT_CYCLES * Q_2_LO / 4);
  localparam logic [TS_W-1:0] WIN_2_HI = TS_W'(BIT_CYCLES * Q_2_HI / 4);

  logic rf_meta;
  logic rf_sync;
  logic rf_prev;
  logic edge_seen;
  logic [TS_W-1:0] timestamp;
  logic [TS_W-1:0] last_ts;
  logic [TS_W-1:0] cur_interval;
  logic [TS_W-1:0] edge_interval;
  mfd_class_t cls;
  mfd_stage_t stage;
  logic decoding;
  logic edge_position_flag;
  logic next_pos;
  logic bit_valid;
  logic bit_value;
  logic pend_valid;
  logic [DATA_BITS-1:0] temp_bit_buffer;
  logic [DATA_BITS-1:0] shifted;
  logic [IDX_W-1:0] buffer_write_index;
  logic [DATA_BITS-1:0] data_word;
  logic fifo_in_ready;

  // ----------------------------------------------------------------
  // input sync and edge capture
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rf_meta <= 1'b0;
      rf_sync <= 1'b0;
      rf_prev <= 1'b0;
    end else begin
      rf_meta <= rf_data;
      rf_sync <= rf_meta;
      rf_prev <= rf_sync;
    end
  end

  assign edge_seen = rf_sync && !rf_prev;
  assign decoding = (stage == ST_ID) || (stage == ST_HDR) || (stage == ST_DATA);

  // timestamp and difference
  // free running; gaps beyond the counter range may alias
  assign cur_interval = timestamp - last_ts;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timestamp <= '0;
      last_ts <= '0;
      edge_interval <= '0;
    end else begin
      timestamp <= timestamp + 1'b1;
      if (edge_seen) begin
        last_ts <= timestamp;
        edge_interval <= cur_interval;
      end
    end
  end

  always_comb begin
    if (cur_interval >= WIN_1_LO && cur_interval < WIN_15_LO) begin
      cls = CL_1;
    end else if (cur_interval >= WIN_15_LO && cur_interval < WIN_2_LO) begin
      cls = CL_15;
    end else if (cur_interval >= WIN_2_LO && cur_interval < WIN_2_HI) begin
      cls = CL_2;
    end else begin
      cls = CL_BAD;
    end
  end

  // ----------------------------------------------------------------
  // edge position and bit emission
  // ----------------------------------------------------------------
  // position update
  always_comb begin
    case (cls)
      CL_1: next_pos = edge_position_flag;
      CL_15: next_pos = !edge_position_flag;
      default: next_pos = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      edge_position_flag <= 1'b0;
    end else if (edge_seen && stage == ST_SEARCH && cls == CL_2) begin
      edge_position_flag <= 1'b0;
    end else if (edge_seen && decoding) begin
      edge_position_flag <= next_pos;
    end
  end

  // second bit follows one cycle later
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bit_valid <= 1'b0;
      bit_value <= 1'b0;
      pend_valid <= 1'b0;
    end else if (edge_seen && decoding && cls != CL_BAD) begin
      bit_valid <= 1'b1;
      bit_value <= (cls == CL_1) ? next_pos : 1'b1;
      pend_valid <= (cls != CL_1) && !next_pos;
    end else if (pend_valid) begin
      bit_valid <= 1'b1;
      bit_value <= 1'b0;
      pend_valid <= 1'b0;
    end else begin
      bit_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // frame stages
  // ----------------------------------------------------------------
  assign shifted = {temp_bit_buffer[DATA_BITS-2:0], bit_value};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stage <= ST_SEARCH;
      buffer_write_index <= '0;
      temp_bit_buffer <= '0;
      data_word <= '0;
    end else begin
      case (stage)
        ST_SEARCH: begin
          // preamble edges ignored
          // only the recovery zero's 010 lead gives a two-bit interval
          if (edge_seen && cls == CL_2) begin
            stage <= ST_ID;
            buffer_write_index <= '0;
            temp_bit_buffer <= '0;
          end
        end
        ST_ID, ST_HDR, ST_DATA: begin
          if (edge_seen && cls == CL_BAD) begin
            stage <= ST_SEARCH;
            buffer_write_index <= '0;
            temp_bit_buffer <= '0;
          end else if (bit_valid) begin
            temp_bit_buffer <= shifted;
            buffer_write_index <= buffer_write_index + 1'b1;
            if (stage == ST_ID && buffer_write_index == IDX_W'(ID_BITS - 1)) begin
              buffer_write_index <= '0;
              temp_bit_buffer <= '0;
              stage <= (shifted[ID_BITS-1:0] == ID_VALUE) ? ST_HDR : ST_SEARCH;
            end
            // data starts with the next bit
            if (stage == ST_HDR && buffer_write_index == IDX_W'(HDR_BITS - 1)) begin
              buffer_write_index <= '0;
              temp_bit_buffer <= '0;
              stage <= (shifted[HDR_BITS-1:0] == HDR_VALUE) ? ST_DATA : ST_SEARCH;
            end
            if (stage == ST_DATA && buffer_write_index == IDX_W'(DATA_BITS - 1)) begin
              buffer_write_index <= '0;
              data_word <= shifted;
              stage <= ST_PUSH;
            end
          end
        end
        ST_PUSH: begin
          // edges are ignored while the fifo is full
          // end of message ignored
          if (fifo_in_ready) begin
            stage <= ST_SEARCH;
          end
        end
        default: stage <= ST_SEARCH;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      decode_error <= 1'b0;
      frame_drop <= 1'b0;
      sync_locked <= 1'b0;
    end else begin
      decode_error <= edge_seen && decoding && cls == CL_BAD;
      frame_drop <= bit_valid && !(edge_seen && cls == CL_BAD) &&
        ((stage == ST_ID && buffer_write_index == IDX_W'(ID_BITS - 1) &&
          shifted[ID_BITS-1:0] != ID_VALUE) ||
         (stage == ST_HDR && buffer_write_index == IDX_W'(HDR_BITS - 1) &&
          shifted[HDR_BITS-1:0] != HDR_VALUE));
      sync_locked <= decoding;
    end
  end

  mfd_fifo #(
    .WIDTH(DATA_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(stage == ST_PUSH),
    .in_data(data_word),
    .in_ready(fifo_in_ready),
    .out_valid(frame_valid),
    .out_data(frame_data),
    .out_ready(frame_ready)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_interval_capture: assert property (
    @(posedge mclk) disable iff (!nrst)
    edge_seen |=> edge_interval == $past(cur_interval))
    else $error("edge interval not captured");

  a_one_bit_keep: assert property (
    @(posedge mclk) disable iff (!nrst)
    edge_seen && decoding && cur_interval >= WIN_1_LO && cur_interval < WIN_15_LO
    |=> $stable(edge_position_flag))
    else $error("one-bit interval moved position");

  a_bad_error: assert property (
    @(posedge mclk) disable iff (!nrst)
    edge_seen && decoding && cls == CL_BAD |=> decode_error && stage == ST_SEARCH)
    else $error("bad interval not reported");

  a_single_bit: assert property (
    @(posedge mclk) disable iff (!nrst)
    edge_seen && decoding && cls == CL_1
    |=> bit_valid && bit_value == $past(edge_position_flag) ##1 !bit_valid)
    else $error("one-bit decode wrong");

  a_pair_bits: assert property (
    @(posedge mclk) disable iff (!nrst)
    edge_seen && decoding && (cls == CL_15 || cls == CL_2) && !next_pos
    |=> bit_valid && bit_value ##1 bit_valid && !bit_value)
    else $error("pair decode wrong");

  a_toggle_pos: assert property (
    @(posedge mclk) disable iff (!nrst)
    edge_seen && decoding && cls == CL_15 |=> edge_position_flag != $past(edge_position_flag))
    else $error("position not toggled");

  a_two_bit_mid: assert property (
    @(posedge mclk) disable iff (!nrst)
    edge_seen && cls == CL_2 && stage != ST_PUSH |=> !edge_position_flag)
    else $error("position not forced to mid");

  a_sync_gate: assert property (
    @(posedge mclk) disable iff (!nrst)
    stage == ST_SEARCH && !(edge_seen && cls == CL_2) |=> stage == ST_SEARCH)
    else $error("left search without sync");

  a_drop_search: assert property (
    @(posedge mclk) disable iff (!nrst)
    frame_drop |-> stage == ST_SEARCH && buffer_write_index == '0)
    else $error("drop without state clear");

  a_push_done: assert property (
    @(posedge mclk) disable iff (!nrst)
    stage == ST_PUSH && fifo_in_ready |=> stage == ST_SEARCH)
    else $error("data word not pushed");

endmodule : mfd_decoder

// ---- logic/mfd_pkg.sv ----
// Purpose: shared constants and types of the Manchester frame decoder
// Assumes: 25 MHz system clock, 9.6 kbaud Manchester line
// Notes: interval windows are in quarters of one bit period
package mfd_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_HZ = 9600;
  // one bit period in clocks, rounded down (2604)
  localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
  // window edges in quarter bits: 0.75, 1.25, 1.75, 2.25
  localparam int Q_1_LO = 3;
  localparam int Q_15_LO = 5;
  localparam int Q_2_LO = 7;
  localparam int Q_2_HI = 9;
  localparam int TS_W = 16;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int ID_BITS = 8;
  localparam logic [ID_BITS-1:0] ID_VALUE = 8'h0f;
  localparam int HDR_BITS = 4;
  localparam logic [HDR_BITS-1:0] HDR_VALUE = 4'h6;
  localparam int DATA_BITS = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int IDX_W = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CL_1, CL_15, CL_2, CL_BAD} mfd_class_t;
  typedef enum logic [2:0] {ST_SEARCH, ST_ID, ST_HDR, ST_DATA, ST_PUSH} mfd_stage_t;

endpackage : mfd_pkg

// ---- tb/mfd_rf_tx.sv ----
// Purpose: behavioural receiver line that feeds the frame decoder
// Assumes: line idles low between frames; bits go out MSB first
// Notes: a cut frame stops early and carries no end of message
`timescale 1ns/1ps

// ------------------------------------------------------------------
// line model
// ------------------------------------------------------------------
module mfd_rf_tx #(
  parameter int BIT_CYCLES = 40
) (
  // clock
  input wire logic mclk,
  // demodulated line
  output logic rf_data
);
  localparam int HB = BIT_CYCLES / 2;

  initial rf_data = 1'b0;

  task automatic hold(input logic lvl, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rf_data <= lvl;
    end
  endtask : hold

  task automatic send_bit(input logic b);
    hold(b, HB);
    hold(~b, HB);
  endtask : send_bit

  task automatic send_frame(input logic [7:0] id, input logic [3:0] hdr,
      input logic [9:0] data, input int cut, input logic fsk);
    logic [24:0] bits;
    bits = {3'b010, id, hdr, data};
    if (fsk) begin
      repeat (3) send_bit(1'b0);
    end else begin
      hold(1'b1, 2 * BIT_CYCLES);
    end
    // the leading zero of the 010 lead is the clock recovery zero
    for (int i = 24; i >= cut; i--) begin
      send_bit(bits[i]);
    end
    if (cut == 0) begin
      hold(1'b1, 2 * BIT_CYCLES);
    end
    // long quiet gap keeps the next lead edge outside every window
    hold(1'b0, 6 * BIT_CYCLES);
  endtask : send_frame
endmodule : mfd_rf_tx

// ---- tb/mfd_decoder_tb.sv ----
// Purpose: self-checking bench for the frame decoder
// Assumes: shortened bit period of 40 clocks
// Notes: words are collected whenever valid and ready meet
`timescale 1ns/1ps

module mfd_decoder_tb;
  import mfd_pkg::*;
  localparam int BC = 40;
  localparam logic [7:0] IDX = 8'h0f;
  localparam logic [3:0] HDX = 4'h6;

  logic mclk;
  logic nrst;
  logic rf_data;
  logic [DATA_BITS-1:0] frame_data;
  logic frame_valid;
  logic frame_ready;
  logic sync_locked;
  logic decode_error;
  logic frame_drop;
  logic lock_q;
  int bad_count = 0;
  int checks = 0;
  int drops = 0;
  int errs = 0;
  int locks = 0;
  logic [DATA_BITS-1:0] got_q[$];

  mfd_decoder #(.BIT_CYCLES(BC)) mfd_decoder_inst (
    .mclk(mclk), .nrst(nrst), .rf_data(rf_data),
    .frame_data(frame_data), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .sync_locked(sync_locked), .decode_error(decode_error), .frame_drop(frame_drop)
  );

  mfd_rf_tx #(.BIT_CYCLES(BC)) mfd_rf_tx_inst (.mclk(mclk), .rf_data(rf_data));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // observers
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    lock_q <= sync_locked;
    if (frame_drop === 1'b1) drops++;
    if (decode_error === 1'b1) errs++;
    if (sync_locked === 1'b1 && lock_q !== 1'b1) locks++;
    if (frame_valid === 1'b1 && frame_ready === 1'b1) got_q.push_back(frame_data);
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // compares word, drop, error and lock counts, then clears them
  task automatic expect_run(input int n_words, input logic [9:0] first, input int n_drop,
      input int n_err, input int n_lock);
    repeat (20) @(posedge mclk);
    check("word count", 16'(n_words), 16'(got_q.size()));
    for (int k = 0; k < got_q.size(); k++) begin
      check("frame word", {6'h00, first + 10'(7 * k)}, {6'h00, got_q[k]});
    end
    check("drop pulses", 16'(n_drop), 16'(drops));
    check("error pulses", 16'(n_err), 16'(errs));
    check("lock rises", 16'(n_lock), 16'(locks));
    check("lock idle", 16'h0000, {15'h0000, sync_locked});
    got_q.delete();
    drops = 0;
    errs = 0;
    locks = 0;
  endtask : expect_run

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_good;
    mfd_rf_tx_inst.send_frame(IDX, HDX, 10'h2b5, 0, 1'b0);
    expect_run(1, 10'h2b5, 0, 0, 1);
    mfd_rf_tx_inst.send_frame(IDX, HDX, 10'h2b5, 0, 1'b1);
    expect_run(1, 10'h2b5, 0, 0, 1);
  endtask : t_good

  task automatic t_bad_id;
    mfd_rf_tx_inst.send_frame(8'h0e, HDX, 10'h3ff, 0, 1'b0);
    expect_run(0, 10'h000, 1, 0, 1);
  endtask : t_bad_id

  task automatic t_bad_hdr;
    mfd_rf_tx_inst.send_frame(IDX, 4'h7, 10'h3ff, 0, 1'b1);
    expect_run(0, 10'h000, 1, 0, 1);
  endtask : t_bad_hdr

  // cut after five id bits: the long gap then breaks decoding
  task automatic t_abort;
    mfd_rf_tx_inst.send_frame(IDX, HDX, 10'h2b5, 17, 1'b0);
    mfd_rf_tx_inst.send_frame(IDX, HDX, 10'h1c6, 0, 1'b0);
    expect_run(1, 10'h1c6, 0, 1, 2);
  endtask : t_abort

  // seventeen frames with the consumer stalled, then one drain
  task automatic t_fifo;
    frame_ready <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      mfd_rf_tx_inst.send_frame(IDX, HDX, 10'h0a3 + 10'(7 * i), 0, 1'(i % 2));
    end
    check("stalled words", 16'h0000, 16'(got_q.size()));
    @(posedge mclk);
    frame_ready <= 1'b1;
    expect_run(17, 10'h0a3, 0, 0, 17);
  endtask : t_fifo

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  initial begin
    nrst = 1'b0;
    frame_ready = 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    frame_ready <= 1'b1;
    repeat (10 * BC) @(posedge mclk);
    t_good();
    t_bad_id();
    t_bad_hdr();
    t_abort();
    t_fifo();
    print_verdict();
  end

  // 23 frames of about 1400 clocks each; this allows well over 30
  initial begin
    #2_000_000;
    bad_count++;
    print_verdict();
  end
endmodule : mfd_decoder_tb
